// ===== inc/clsc_pkg.sv
// constants and types for the coax line symbol control block
`default_nettype none
package clsc_pkg;

   localparam int CLK_PERIOD_NS  = 5;
   localparam int SYMBOL_TIME_NS = 200;
   localparam int SYMBOL_CYCLES  = SYMBOL_TIME_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_POINT   = SYMBOL_CYCLES / 2;
   localparam int PHASE_W        = $clog2(SYMBOL_CYCLES);

   localparam int FIFO_DEPTH     = 16;
   localparam int RX_WORD_W      = 2;
   // word layout: bit 1 first sample after carrier rise, bit 0 level
   localparam int RX_FIRST_BIT   = 1;
   localparam int RX_LEVEL_BIT   = 0;

   localparam logic RX_LEVEL_RST   = 1'b0;
   localparam logic RX_CARRIER_RST = 1'b0;
   localparam logic [1:0] SYNC_RST = 2'h0;

   typedef enum logic [2:0]
   {
      CLSC_TX_OFF  = 3'b001,
      CLSC_TX_HIGH = 3'b010,
      CLSC_TX_LOW  = 3'b100
   } clsc_tx_state_t;

endpackage
`default_nettype wire

// ===== inc/clsc_stream_if.sv
// valid/ready stream carrier between the block and its fifo
`timescale 1ns/10ps
`default_nettype none
interface clsc_stream_if
#(
   parameter int WIDTH = 2
);
   logic             in_valid;
   logic             in_ready;
   logic [WIDTH-1:0] in_data;
   logic             out_valid;
   logic             out_ready;
   logic [WIDTH-1:0] out_data;

   modport fifo
   (
      input  in_valid,
      input  in_data,
      output in_ready,
      output out_valid,
      output out_data,
      input  out_ready
   );

   modport user
   (
      output in_valid,
      output in_data,
      input  in_ready,
      input  out_valid,
      input  out_data,
      output out_ready
   );
endinterface
`default_nettype wire

// ===== hw/clsc_fifo.sv
// parameterised first-word fifo for received symbol samples
`timescale 1ns/10ps
`default_nettype none
module clsc_fifo
#(
   parameter int WIDTH = 2,
   parameter int DEPTH = 16
)
(
   input  wire logic   clk,
   input  wire logic   rst,
   clsc_stream_if.fifo st
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin
      $error("clsc_fifo: DEPTH must be a power of two, at least 2");
   end
   if (WIDTH < 1)
   begin
      $error("clsc_fifo: WIDTH must be at least 1");
   end

   // extra pointer bit tells full from empty without a counter
   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign push  = st.in_valid && !full;
   assign pop   = st.out_ready && !empty;

   assign st.in_ready  = !full;
   assign st.out_valid = !empty;
   assign st.out_data  = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr_reg[AW-1:0]] <= st.in_data;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wr_ptr_reg <= '0;
      else if (push)
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_ptr_reg <= '0;
      else if (pop)
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
   end
endmodule
`default_nettype wire

// ===== hw/clsc_coax_line.sv
// transmit control and receive indication logic of the coax attachment
`timescale 1ns/10ps
`default_nettype none
module clsc_coax_line
#(
   parameter int FIFO_WORDS = clsc_pkg::FIFO_DEPTH
)
(
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           tx_positive_drive,
   input  wire logic                           tx_negative_drive,
   input  wire logic                           line_drive_enable,
   output logic                                line_drive_high,
   output logic                                line_drive_low,
   output logic                                line_oe,
   output logic                                tx_request_fault,
   input  wire logic                           rx_above_pos_limit,
   input  wire logic                           rx_below_neg_limit,
   input  wire logic                           rx_above_carrier_high,
   input  wire logic                           rx_below_carrier_low,
   output logic                                rx_level_indication,
   output logic                                rx_signal_present,
   output logic                                rx_word_valid,
   output logic [clsc_pkg::RX_WORD_W-1:0]      rx_word_data,
   input  wire logic                           rx_word_ready,
   output logic                                rx_overrun
);
   import clsc_pkg::*;

   // refused at elaboration, before any logic is built
   if (FIFO_WORDS < 2 || (FIFO_WORDS & (FIFO_WORDS - 1)) != 0)
   begin
      $error("clsc_coax_line: FIFO_WORDS must be a power of two");
   end
   if (SYMBOL_CYCLES < 4)
   begin
      $error("clsc_coax_line: symbol period too short for clock");
   end

   // ------------------------------------------------------------------
   // transmit side
   // ------------------------------------------------------------------

   clsc_tx_state_t tx_state_reg;
   clsc_tx_state_t tx_state_next;
   logic           tx_fault_reg;
   logic           tx_fault_next;

   function automatic clsc_tx_state_t decode_symbol
   (
      input logic pos,
      input logic neg,
      input logic en
   );
      clsc_tx_state_t s;
      s = CLSC_TX_OFF;
      if (!en || (!pos && !neg))
         s = CLSC_TX_OFF;
      else if (pos && !neg)
         s = CLSC_TX_HIGH;
      else if (!pos && neg)
         s = CLSC_TX_LOW;
      // forbidden pair kept off to protect the driver
      else
         s = CLSC_TX_OFF;
      return s;
   endfunction

   function automatic logic is_forbidden
   (
      input logic pos,
      input logic neg,
      input logic en
   );
      return en && pos && neg;
   endfunction

   // only the three lines select the symbol
   always_comb
   begin
      tx_state_next = decode_symbol(tx_positive_drive,
                                    tx_negative_drive,
                                    line_drive_enable);
      tx_fault_next = is_forbidden(tx_positive_drive,
                                   tx_negative_drive,
                                   line_drive_enable);
   end

   // lines come from logic on this clock, so no synchroniser
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tx_state_reg <= CLSC_TX_OFF;
      else
         tx_state_reg <= tx_state_next;
   end

   // flag shows a forbidden request while it stands
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         tx_fault_reg <= 1'b0;
      else
         tx_fault_reg <= tx_fault_next;
   end

   // one wire, driven high, low or released
   always_comb
   begin
      line_drive_high = 1'b0;
      line_drive_low  = 1'b0;
      line_oe         = 1'b0;
      unique case (tx_state_reg)
         CLSC_TX_OFF:
         begin
            line_oe = 1'b0;
         end
         CLSC_TX_HIGH:
         begin
            line_drive_high = 1'b1;
            line_oe         = 1'b1;
         end
         CLSC_TX_LOW:
         begin
            line_drive_low = 1'b1;
            line_oe        = 1'b1;
         end
         default:
         begin
            line_oe = 1'b0;
         end
      endcase
   end

   assign tx_request_fault = tx_fault_reg;

   // ------------------------------------------------------------------
   // receive side
   // ------------------------------------------------------------------

   // comparator outputs are analog-derived, so two flops each
   logic [3:0] cmp_meta_reg;
   logic [3:0] cmp_sync_reg;
   logic       level_reg;
   logic       carrier_reg;
   logic       carrier_prev_reg;
   logic       level_prev_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmp_meta_reg <= 4'h0;
         cmp_sync_reg <= 4'h0;
      end
      else
      begin
         cmp_meta_reg <= {rx_below_carrier_low, rx_above_carrier_high,
                          rx_below_neg_limit, rx_above_pos_limit};
         cmp_sync_reg <= cmp_meta_reg;
      end
   end

   // hysteresis holds the level between the limits
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         level_reg <= RX_LEVEL_RST;
      else if (cmp_sync_reg[0] && !cmp_sync_reg[1])
         level_reg <= 1'b1;
      else if (cmp_sync_reg[1] && !cmp_sync_reg[0])
         level_reg <= 1'b0;
   end

   // carrier hysteresis between low and high limits
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         carrier_reg <= RX_CARRIER_RST;
      else if (cmp_sync_reg[2] && !cmp_sync_reg[3])
         carrier_reg <= 1'b1;
      else if (cmp_sync_reg[3] && !cmp_sync_reg[2])
         carrier_reg <= 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         carrier_prev_reg <= RX_CARRIER_RST;
         level_prev_reg   <= RX_LEVEL_RST;
      end
      else
      begin
         carrier_prev_reg <= carrier_reg;
         level_prev_reg   <= level_reg;
      end
   end

   // both indications go straight back to the sublayer
   assign rx_level_indication = level_reg;
   assign rx_signal_present   = carrier_reg;

   // ------------------------------------------------------------------
   // symbol sampler feeding the fifo
   // ------------------------------------------------------------------

   logic               carrier_rise;
   logic               level_edge;
   logic [PHASE_W-1:0] phase_reg;
   logic               at_sample;
   logic               first_reg;
   logic               pend_valid_reg;
   logic [RX_WORD_W-1:0] pend_data_reg;
   logic               overrun_reg;
   logic               capture;
   logic               pushed;

   clsc_stream_if #(.WIDTH(RX_WORD_W)) rx_st ();

   assign carrier_rise = carrier_reg && !carrier_prev_reg;
   assign level_edge   = level_reg != level_prev_reg;
   assign at_sample    = phase_reg == PHASE_W'(SAMPLE_POINT);

   // phase realigns on every line edge so sampling stays mid-symbol
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         phase_reg <= '0;
      else if (carrier_rise || level_edge)
         phase_reg <= '0;
      else if (phase_reg == PHASE_W'(SYMBOL_CYCLES - 1))
         phase_reg <= '0;
      else
         phase_reg <= phase_reg + 1'b1;
   end

   // level is only meaningful while carrier stands
   // a sample point falling on the carrier rise is stale phase, skip it
   assign capture = at_sample && carrier_reg && !carrier_rise;
   assign pushed  = pend_valid_reg && rx_st.in_ready;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         first_reg <= 1'b0;
      else if (carrier_rise)
         first_reg <= 1'b1;
      else if (capture && (!pend_valid_reg || pushed))
         first_reg <= 1'b0;
   end

   // a full fifo stalls the sampler; the held word is not overwritten
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pend_valid_reg <= 1'b0;
         pend_data_reg  <= '0;
      end
      else if (capture && (!pend_valid_reg || pushed))
      begin
         pend_valid_reg <= 1'b1;
         pend_data_reg[RX_FIRST_BIT] <= first_reg;
         pend_data_reg[RX_LEVEL_BIT] <= level_reg;
      end
      else if (pushed)
         pend_valid_reg <= 1'b0;
   end

   // sticky loss flag, cleared by the next frame; a loss wins the clear
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         overrun_reg <= 1'b0;
      else if (capture && pend_valid_reg && !pushed)
         overrun_reg <= 1'b1;
      else if (carrier_rise)
         overrun_reg <= 1'b0;
   end

   assign rx_st.in_valid  = pend_valid_reg;
   assign rx_st.in_data   = pend_data_reg;
   assign rx_st.out_ready = rx_word_ready;

   clsc_fifo
   #(
      .WIDTH (RX_WORD_W),
      .DEPTH (FIFO_WORDS)
   )
   u_rx_fifo
   (
      .clk (clk),
      .rst (rst),
      .st  (rx_st)
   );

   assign rx_word_valid = rx_st.out_valid;
   assign rx_word_data  = rx_st.out_data;
   assign rx_overrun    = overrun_reg;

endmodule
`default_nettype wire

// ===== verif/clsc_sublayer_model.sv
// sublayer model driving the three transmit control lines
`timescale 1ns/10ps
`default_nettype none
module clsc_sublayer_model
(
   input  wire logic clk,
   input  wire logic allow_bad,
   output var  logic pos,
   output var  logic neg,
   output var  logic en
);
   logic [2:0] r;
   always @(negedge clk)
   begin
      r = 3'($urandom);
      if (r == 3'h7 && !allow_bad)
         r[1] = 1'b0;
      {pos, neg, en} <= r;
   end
endmodule
`default_nettype wire

// ===== verif/clsc_coax_line_checker.sv
// concurrent checks on the coax line symbol control ports
`timescale 1ns/10ps
`default_nettype none
module clsc_coax_line_checker
(
   input wire logic                         clk,
   input wire logic                         rst,
   input wire logic                         tx_positive_drive,
   input wire logic                         tx_negative_drive,
   input wire logic                         line_drive_enable,
   input wire logic                         line_drive_high,
   input wire logic                         line_drive_low,
   input wire logic                         line_oe,
   input wire logic                         tx_request_fault,
   input wire logic                         rx_above_pos_limit,
   input wire logic                         rx_below_neg_limit,
   input wire logic                         rx_above_carrier_high,
   input wire logic                         rx_below_carrier_low,
   input wire logic                         rx_level_indication,
   input wire logic                         rx_signal_present,
   input wire logic                         rx_word_valid,
   input wire logic [clsc_pkg::RX_WORD_W-1:0] rx_word_data,
   input wire logic                         rx_word_ready
);
   wire logic en = line_drive_enable;
   wire logic req_h = en && tx_positive_drive && !tx_negative_drive;
   wire logic req_l = en && !tx_positive_drive && tx_negative_drive;
   wire logic req_bad = en && tx_positive_drive && tx_negative_drive;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_tx_high_map: assert property (
      req_h |=> line_oe && line_drive_high && !line_drive_low)
      else $error("H request not driven positive");
   a_tx_low_map: assert property (
      req_l |=> line_oe && line_drive_low && !line_drive_high)
      else $error("L request not driven negative");
   a_tx_off_map: assert property (
      !req_h && !req_l |=> !line_oe && !line_drive_high && !line_drive_low)
      else $error("transmitter not off");
   a_bad_flag: assert property (
      req_bad |=> tx_request_fault && !line_oe)
      else $error("forbidden request not refused");
   a_single_ended: assert property (
      line_oe == (line_drive_high ^ line_drive_low))
      else $error("line drive not single ended");
   a_level_set: assert property (
      (rx_above_pos_limit && !rx_below_neg_limit) [*3] |=> rx_level_indication)
      else $error("data indication not set");
   a_level_clear: assert property (
      (rx_below_neg_limit && !rx_above_pos_limit) [*3]
      |=> !rx_level_indication)
      else $error("data indication not cleared");
   a_carrier_set: assert property (
      (rx_above_carrier_high && !rx_below_carrier_low) [*3]
      |=> rx_signal_present)
      else $error("carrier indication not set");
   a_carrier_clear: assert property (
      (rx_below_carrier_low && !rx_above_carrier_high) [*3]
      |=> !rx_signal_present)
      else $error("carrier indication not cleared");
   a_word_hold: assert property (
      rx_word_valid && !rx_word_ready |=> rx_word_valid && $stable(rx_word_data))
      else $error("stalled word not held");
endmodule
bind clsc_coax_line clsc_coax_line_checker chk_i (.*);
`default_nettype wire

// ===== verif/clsc_coax_line_tb.sv
// self-checking bench for the coax line symbol control block
`timescale 1ns/10ps
`default_nettype none
module clsc_coax_line_tb;
   import clsc_pkg::*;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 pos, neg, en, hi, lo, oe, flt, ovr;
   logic                 bad = 1'b0;
   logic                 stall = 1'b0;
   logic                 lvl_ind, car_ind, w_valid;
   logic                 w_ready = 1'b0;
   logic [RX_WORD_W-1:0] w_data;
   logic                 ap = 1'b0, bn = 1'b1, ch = 1'b0, cl = 1'b1;
   logic [RX_WORD_W-1:0] exp_q[$];
   logic [2:0]           tx_exp = 3'h0;
   logic                 tx_fexp = 1'b0;
   logic                 tx_armed = 1'b0;
   int                   err_total = 0;
   int                   compares = 0;
   logic [2:0]           s_tx;
   logic                 s_flt;
   logic                 s_valid;
   logic [RX_WORD_W-1:0] s_data;

   clsc_coax_line #(.FIFO_WORDS(16)) uut
   (
      .clk(clk), .rst(rst), .tx_positive_drive(pos),
      .tx_negative_drive(neg), .line_drive_enable(en),
      .line_drive_high(hi), .line_drive_low(lo), .line_oe(oe),
      .tx_request_fault(flt), .rx_above_pos_limit(ap),
      .rx_below_neg_limit(bn), .rx_above_carrier_high(ch),
      .rx_below_carrier_low(cl), .rx_level_indication(lvl_ind),
      .rx_signal_present(car_ind), .rx_word_valid(w_valid),
      .rx_word_data(w_data), .rx_word_ready(w_ready), .rx_overrun(ovr)
   );
   clsc_sublayer_model sub
   (
      .clk(clk), .allow_bad(bad), .pos(pos), .neg(neg), .en(en)
   );

   initial
      forever #2.5 clk = ~clk;

   task automatic chk(input string what, input logic [3:0] e,
                      input logic [3:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic final_report;
      if (err_total == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // one symbol per 40 cycles; first k samples are expected to survive
   task automatic burst(input int n, input int k);
      logic l;
      for (int i = 0; i < n; i++)
      begin
         l = 1'($urandom);
         @(negedge clk);
         {ap, bn, ch, cl} = {l, !l, 2'b10};
         if (i < k)
            exp_q.push_back({i == 0, l});
         repeat (39) @(negedge clk);
      end
      @(negedge clk);
      {ch, cl} = 2'b01;
      repeat (80) @(negedge clk);
   endtask

   task automatic drain;
      stall = 1'b0;
      for (int t = 0; t < 2000 && exp_q.size() > 0; t++)
         @(negedge clk);
      chk("rx words left", 4'h0, 4'(exp_q.size()));
   endtask

   // sink stalls at random so words queue up in the fifo
   always @(negedge clk)
      w_ready <= stall ? 1'b0 : 1'($urandom);

   // outputs taken mid-cycle, where they have settled for the next edge
   always @(negedge clk)
   begin
      s_tx    = {oe, hi, lo};
      s_flt   = flt;
      s_valid = w_valid;
      s_data  = w_data;
   end

   always @(posedge clk)
   begin
      if (tx_armed)
      begin
         chk("tx lines", {1'b0, tx_exp}, {1'b0, s_tx});
         chk("tx fault", {3'h0, tx_fexp}, {3'h0, s_flt});
      end
      tx_armed <= !rst;
      tx_fexp <= en && pos && neg;
      tx_exp <= (!en || pos == neg) ? 3'h0 : {1'b1, pos, neg};
      if (s_valid === 1'b1 && w_ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk("rx extra word", 4'h0, {3'h0, s_valid});
         else
            chk("rx word", {2'h0, exp_q.pop_front()}, {2'h0, s_data});
      end
   end

   initial
   begin
      void'($urandom(32'h2b17));
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (20) @(negedge clk);
      burst(10, 10);
      drain();
      // fifo full plus holding slot, one sample lost
      bad = 1'b1;
      stall = 1'b1;
      burst(18, 17);
      chk("overrun", 4'h1, {3'h0, ovr});
      drain();
      bad = 1'b0;
      burst(2, 2);
      chk("overrun clear", 4'h0, {3'h0, ovr});
      drain();
      {ap, bn} = 2'b10;
      repeat (5) @(negedge clk);
      {ap, bn, ch, cl} = 4'h3;
      repeat (5) @(negedge clk);
      chk("level hold", 4'h1, {3'h0, lvl_ind});
      chk("carrier hold", 4'h0, {3'h0, car_ind});
      {ap, bn} = 2'b01;
      repeat (5) @(negedge clk);
      chk("level clear", 4'h0, {3'h0, lvl_ind});
      final_report();
   end

   initial
   begin
      #(5 * 20000);
      err_total++;
      final_report();
   end
endmodule
`default_nettype wire
